// >>> src/dsa_pkg.sv
/*
 * dsa_pkg: constants shared by the dual sampling converter
 * host port. Assumes a single 125 MHz clock domain.
 */
package dsa_pkg;
	localparam int unsigned CLK_PERIOD_PS   = 8000;
	localparam int unsigned CONV_TIME_NS    = 5200;
	// longest time: round down, never below one cycle
	localparam int unsigned CONV_CYCLES_RAW = (CONV_TIME_NS * 1000) /
		CLK_PERIOD_PS;
	localparam int unsigned CONV_CYCLES     = (CONV_CYCLES_RAW < 1) ? 1 :
		CONV_CYCLES_RAW;
	localparam int unsigned DATA_W          = 14;
	localparam int unsigned FIFO_DEPTH      = 16;
	localparam int unsigned CNT_W           = 12;
	localparam logic        GROUP_A         = 1'b0;
	localparam logic        GROUP_B         = 1'b1;
endpackage : dsa_pkg

// >>> src/dsa_fifo.sv
/*
 * dsa_fifo: synchronous FIFO with valid/ready on both sides.
 * Assumes writer and reader share clk_in; width and depth are parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module dsa_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic [WIDTH-1:0]      rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	input  wire logic             flush_in
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("dsa_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} dsa_fifo_st_t;

	dsa_fifo_st_t     s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push, pop;

	assign wr_ready_out = (s_q.cnt != (AW+1)'(DEPTH));
	assign rd_valid_out = (s_q.cnt != '0);
	assign rd_data_out  = mem[s_q.rp];
	assign push = ce_in && wr_valid_in && wr_ready_out && !flush_in;
	assign pop  = ce_in && rd_valid_out && rd_ready_in && !flush_in;

	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wp = s_q.wp + 1'b1;
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
		if (ce_in && flush_in)
			s_d = '0;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			s_q <= '0;
		else if (ce_in)
			s_q <= s_d;
	end

	// storage has no reset: contents are only read while counted valid
	always_ff @(posedge clk_in) begin
		if (push)
			mem[s_q.wp] <= wr_data_in;
	end
endmodule : dsa_fifo
`default_nettype wire

// >>> src/dsa_host_port.sv
/*
 * dsa_host_port: conversion control and parallel readout of a dual
 * simultaneous-sampling 14-bit converter.
 * Assumes the converter cores and track/holds sit outside; pins from the
 * host are asynchronous; all but auto_power_down_in pass a three-stage synchroniser.
 *
// Summary of operation
// RULE_01 - start strobe holds both channels, starts both
// RULE_02 - busy marks conversion end, results ready
// RULE_03 - group select low picks A, high B
// RULE_04 - first read input 1, second input 2
// RULE_05 - 14-bit bus qualified by chip select, read
// RULE_06 - results ready within 5.2 us of start
// RULE_07 - power down after conversion, wake before next
// RULE_08 - host waits for busy low, selects beforehand
 */
`timescale 1ns/1ps
`default_nettype none
module dsa_host_port
	import dsa_pkg::*;
#(
	parameter int unsigned CONV_CYC = CONV_CYCLES
) (
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	input  wire logic              ce_in,
	input  wire logic              conversion_start_n_in,
	input  wire logic              channel_group_select_in,
	input  wire logic              cs_n_in,
	input  wire logic              rd_n_in,
	input  wire logic              auto_power_down_in,
	output logic                   track_hold_out,
	output logic                   channel_group_out,
	output logic                   conv_start_out,
	input  wire logic [DATA_W-1:0] core1_result_in,
	input  wire logic [DATA_W-1:0] core2_result_in,
	input  wire logic              core_done_in,
	output logic                   busy_out,
	output logic                   power_down_out,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe_out
);
	// the budget counter needs room for the last count below CONV_CYC
	if (CONV_CYC < 2 || CONV_CYC >= (1 << CNT_W)) begin : g_bad_conv
		$error("dsa_host_port: CONV_CYC out of range");
	end
	// one conversion queues two results back to back
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("dsa_host_port: FIFO_DEPTH below two");
	end
	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CONV_CYC - 2);

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_LOAD = 3'h4
	} dsa_state_t;

	typedef struct packed {
		dsa_state_t          st;
		logic [2:0]          cv_sync;
		logic [2:0]          cs_sync;
		logic [2:0]          rd_sync;
		logic [2:0]          sel_sync;
		logic                cv_lvl;
		logic                sel_lvl;
		logic                rd_act;
		logic [CNT_W-1:0]    cnt;
		logic                grp;
		logic                busy;
		logic                pd;
		logic                start;
		logic                hold;
		logic [DATA_W-1:0]   r2;
		logic [DATA_W-1:0]   dout;
		logic                oe;
	} dsa_st_t;

	dsa_st_t           s_q, s_d;
	logic              cv_n, rd_low, sel_now;
	logic              push, flush, pop;
	logic [DATA_W-1:0] push_data;
	logic              f_ready, f_valid;
	logic [DATA_W-1:0] f_data;

	// a change counts once stages two and three agree
	always_comb begin
		cv_n = s_q.cv_lvl;
		if (s_q.cv_sync[1] == s_q.cv_sync[2]) begin
			cv_n = s_q.cv_sync[2];
		end
		rd_low = s_q.rd_act;
		if (s_q.rd_sync[1] == s_q.rd_sync[2] &&
		    s_q.cs_sync[1] == s_q.cs_sync[2]) begin
			rd_low = !s_q.rd_sync[2] && !s_q.cs_sync[2]; // RULE_05
		end
		// the group level is qualified like the strobes, so a select
		// moving just before a start cannot give a torn value
		sel_now = s_q.sel_lvl;
		if (s_q.sel_sync[1] == s_q.sel_sync[2]) begin
			sel_now = s_q.sel_sync[2];
		end
	end

	// results enter the readout FIFO in read order; a new start drops
	// unread results so reads always pair with the latest conversion
	assign flush = (s_q.st == ST_IDLE) && s_q.cv_lvl && !cv_n;
	assign pop   = rd_low && !s_q.rd_act; // RULE_04

	always_comb begin
		s_d = s_q;
		push = 1'b0;
		push_data = core1_result_in;
		s_d.cv_sync  = {s_q.cv_sync[1:0], conversion_start_n_in};
		s_d.cs_sync  = {s_q.cs_sync[1:0], cs_n_in};
		s_d.rd_sync  = {s_q.rd_sync[1:0], rd_n_in};
		s_d.sel_sync = {s_q.sel_sync[1:0], channel_group_select_in};
		s_d.cv_lvl   = cv_n;
		s_d.sel_lvl  = sel_now;
		s_d.rd_act   = rd_low;
		s_d.start    = 1'b0;
		unique case (s_q.st)
			ST_IDLE: begin
				// wake a cycle ahead of the take so the cores
				// are up for the start; noise only costs power
				if (s_q.cv_lvl && !s_q.cv_sync[1]) begin
					s_d.pd = 1'b0; // RULE_07
				end
				if (flush) begin
					s_d.hold  = 1'b1; // RULE_01
					s_d.start = 1'b1; // RULE_01
					if (sel_now == GROUP_B) begin
						s_d.grp = GROUP_B; // RULE_03
					end else begin
						s_d.grp = GROUP_A; // RULE_03
					end
					s_d.busy  = 1'b1;
					s_d.pd    = 1'b0; // RULE_07
					s_d.cnt   = '0;
					s_d.st    = ST_CONV;
				end
			end
			ST_CONV: begin
				s_d.cnt = s_q.cnt + 1'b1;
				// the cycle budget forces completion if the core is late,
				// so busy never outlasts the conversion time
				if (core_done_in ||
				    s_q.cnt == LAST_CNT) begin // RULE_06
					push      = 1'b1;
					push_data = core1_result_in; // RULE_04
					s_d.r2    = core2_result_in;
					s_d.st    = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// a full FIFO keeps busy up till result two is queued
				if (f_ready) begin
					push      = 1'b1;
					push_data = s_q.r2; // RULE_04
					s_d.busy  = 1'b0; // RULE_02
					s_d.hold  = 1'b0;
					s_d.pd    = auto_power_down_in; // RULE_07
					s_d.st    = ST_IDLE;
				end
			end
			default: begin
				// an upset state code returns to idle
				s_d.st   = ST_IDLE;
				s_d.busy = 1'b0;
				s_d.hold = 1'b0;
				s_d.pd   = 1'b0;
			end
		endcase
		// data output driven from flip-flops, latched at read start;
		// an empty read drives zeros rather than a stale result
		if (pop) begin
			s_d.dout = f_valid ? f_data : '0;
		end
		s_d.oe = rd_low; // RULE_05
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// synchronisers start at their pins' idle level: no false edge
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.cv_sync <= 3'h7;
			s_q.cs_sync <= 3'h7;
			s_q.rd_sync <= 3'h7;
			s_q.cv_lvl  <= 1'b1;
			s_q.sel_sync <= {3{GROUP_A}};
			s_q.sel_lvl <= GROUP_A;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	dsa_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.resetn_in    (resetn_in),
		.ce_in        (ce_in),
		.wr_data_in   (push_data),
		.wr_valid_in  (push),
		.wr_ready_out (f_ready),
		.rd_data_out  (f_data),
		.rd_valid_out (f_valid),
		.rd_ready_in  (pop),
		.flush_in     (flush)
	);

	// every output is a register bit, so none can glitch
	assign track_hold_out    = s_q.hold;
	assign channel_group_out = s_q.grp;
	assign conv_start_out    = s_q.start;
	assign busy_out          = s_q.busy; // RULE_02
	assign power_down_out    = s_q.pd;
	assign data_out          = s_q.dout;
	assign data_oe_out       = s_q.oe;
endmodule : dsa_host_port
`default_nettype wire

// >>> sim/dsa_host_port_checker.sv
/* dsa_host_port_checker: timing checks on the host port.
 * Assumes one clock; bound to dsa_host_port. */
`timescale 1ns/1ps
`default_nettype none
module dsa_host_port_checker
	import dsa_pkg::*;
#(
	parameter int unsigned CONV_CYC = 650
) (
	input wire logic              clk_in,
	input wire logic              resetn_in,
	input wire logic              conv_start_out,
	input wire logic              track_hold_out,
	input wire logic              busy_out,
	input wire logic              power_down_out,
	input wire logic              auto_power_down_in,
	input wire logic              core_done_in,
	input wire logic              data_oe_out,
	input wire logic [DATA_W-1:0] data_out
);
	localparam int BM = CONV_CYC;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_start_holds: assert property (
		conv_start_out |-> track_hold_out && busy_out)
		else $error("start without hold and busy");
	a_start_pulse: assert property (
		conv_start_out |=> !conv_start_out)
		else $error("start pulse too long");
	a_hold_ends: assert property (
		$fell(busy_out) |-> !track_hold_out)
		else $error("hold kept after conversion");
	a_no_restart: assert property (
		busy_out |=> !conv_start_out)
		else $error("start taken while busy");
	a_done_ends: assert property (
		core_done_in && busy_out |-> ##[1:2] !busy_out)
		else $error("busy stays after done");
	a_busy_bound: assert property (
		$rose(busy_out) |-> ##[1:BM] !busy_out)
		else $error("conversion too long");
	a_pd_wake: assert property (
		busy_out |-> !power_down_out)
		else $error("powered down while busy");
	a_pd_enter: assert property (
		$fell(busy_out) && auto_power_down_in |-> power_down_out)
		else $error("no power down after conversion");
	a_data_stands: assert property (
		!data_oe_out |-> $stable(data_out))
		else $error("data changed outside a read");
	c_conv: cover property ($fell(busy_out));
	c_read: cover property ($rose(data_oe_out));
	c_pd: cover property ($rose(power_down_out));
	c_pd_wake: cover property ($fell(power_down_out));
endmodule // dsa_host_port_checker
bind dsa_host_port dsa_host_port_checker #(
	.CONV_CYC (CONV_CYC)
) i_dsa_host_port_checker (
	.clk_in             (clk_in),
	.resetn_in          (resetn_in),
	.conv_start_out     (conv_start_out),
	.track_hold_out     (track_hold_out),
	.busy_out           (busy_out),
	.power_down_out     (power_down_out),
	.auto_power_down_in (auto_power_down_in),
	.core_done_in       (core_done_in),
	.data_oe_out        (data_oe_out),
	.data_out           (data_out)
);
`default_nettype wire

// >>> sim/dsa_core_model.sv
/* dsa_core_model: both converter cores behind the host port.
 * Assumes the host port's clock; mute_in withholds done. */
`timescale 1ns/1ps
`default_nettype none
module dsa_core_model
	import dsa_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         start_in,
	input  wire logic         group_in,
	input  wire logic         mute_in,
	output logic [DATA_W-1:0] r1_out,
	output logic [DATA_W-1:0] r2_out,
	output var logic          done_out
);
	logic [2:0]        cnt = 3'h0;
	logic [DATA_W-1:0] v1, v2;
	assign v1 = group_in ? 14'h2b1c : 14'h0a51;
	assign v2 = group_in ? 14'h3d02 : 14'h1e6f;
	// results inverted outside done so a late capture is caught
	assign r1_out = done_out ? v1 : ~v1;
	assign r2_out = done_out ? v2 : ~v2;
	initial done_out = 1'b0;
	always @(posedge clk_in) begin
		done_out <= (cnt == 3'h1) && !mute_in;
		cnt <= start_in ? 3'h4 : (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
	end
endmodule // dsa_core_model
`default_nettype wire

// >>> sim/dual_sampling_adc_host_port_test.sv
/* dual_sampling_adc_host_port_test: drives host pins, checks results.
 * Assumes a short conversion count of 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module dual_sampling_adc_host_port_test;
	import dsa_pkg::*;
	logic clk_in = 0, resetn_in = 0, cst_n = 1, grp = 0, cs_n = 1, rd_n = 1;
	logic apd = 0, mute = 0, ce = 1, th, cg, cv, done, busy, pd, oe;
	logic [DATA_W-1:0] r1, r2, dout;
	int fails = 0, tests_run = 0, cyc = 0, n = 0;
	always #4 clk_in = ~clk_in;
	dsa_host_port #(.CONV_CYC(8)) i_dsa_host_port (.clk_in(clk_in),
		.resetn_in(resetn_in), .ce_in(ce), .conversion_start_n_in(cst_n),
		.channel_group_select_in(grp), .cs_n_in(cs_n), .rd_n_in(rd_n),
		.auto_power_down_in(apd), .track_hold_out(th),
		.channel_group_out(cg), .conv_start_out(cv), .core1_result_in(r1),
		.core2_result_in(r2), .core_done_in(done), .busy_out(busy),
		.power_down_out(pd), .data_out(dout), .data_oe_out(oe));
	dsa_core_model i_dsa_core_model (.clk_in(clk_in), .start_in(cv),
		.group_in(cg), .mute_in(mute), .r1_out(r1), .r2_out(r2),
		.done_out(done));
	task automatic report_and_stop;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(output logic [DATA_W-1:0] v);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		for (int i = 0; i < 20 && oe !== 1'b1; i++) @(posedge clk_in);
		v = dout;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (5) @(posedge clk_in);
	endtask
	task automatic t_group(input logic g, a);
		int len;
		logic gs, hs;
		logic [DATA_W-1:0] v;
		len = 0;
		apd <= a;
		grp <= g;
		@(posedge clk_in) cst_n <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_in);
			if (i == 4) cst_n <= 1'b1;
			if (busy === 1'b1) begin
				len++;
				gs = cg;
				hs = th;
			end else if (len > 0) break;
		end
		chk(DATA_W'(len > 0 && len <= 8), 14'h1);
		chk(DATA_W'(hs), 14'h1);
		chk(DATA_W'(th), 14'h0);
		chk(DATA_W'(gs), DATA_W'(g));
		chk(DATA_W'(pd), DATA_W'(a));
		rd(v);
		chk(v, g ? 14'h2b1c : 14'h0a51);
		rd(v);
		chk(v, g ? 14'h3d02 : 14'h1e6f);
		rd(v);
		chk(v, 14'h0);
		$display("group test %0d done", g);
	endtask
	task automatic t_refuse;
		n = 0;
		mute <= 1'b1;
		cst_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		cst_n <= 1'b1;
		repeat (2) @(posedge clk_in);
		cst_n <= 1'b0;
		repeat (3) @(posedge clk_in);
		cst_n <= 1'b1;
		repeat (20) @(posedge clk_in);
		chk(DATA_W'(n), 14'h1);
		chk(DATA_W'(busy), 14'h0);
		mute <= 1'b0;
		$display("refuse test done");
	endtask
	// a strobe that comes and goes while frozen must leave no trace
	task automatic t_freeze;
		n = 0;
		ce <= 1'b0;
		cst_n <= 1'b0;
		repeat (8) @(posedge clk_in);
		cst_n <= 1'b1;
		@(posedge clk_in) ce <= 1'b1;
		repeat (8) @(posedge clk_in);
		chk(DATA_W'(n), 14'h0);
		chk(DATA_W'(busy), 14'h0);
		$display("freeze test done");
	endtask
	always @(posedge clk_in) begin
		if (cv === 1'b1) n++;
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop;
		end
	end
	initial begin
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		t_freeze;
		t_group(1'b0, 1'b1);
		t_group(1'b1, 1'b0);
		t_refuse;
		t_group(1'b1, 1'b1);
		report_and_stop;
	end
endmodule // dual_sampling_adc_host_port_test
`default_nettype wire
